// ===== src/fmc_defines.svh
// Constants of the flash mode control block
// Functional notes
// - Flash array occupies H'0000 to H'7FFF when enabled
// - Sixteen-bit path, byte and word reads in two states
// - Mode pins: 00 illegal, 01 external, 1x flash
// - Flash registers reachable only with programming supply
// - Mode 2 without supply: register addresses go external
// - Mode 3 without supply: writes ignored, reads H'FF
// - Mode 1: flash registers unwritable, read H'FF
// - Enabled reset values H'00, H'00, large H'F0
// - Mode control clears on reset, standby, no supply
// - Bit 7 shows programming supply present
// - Bits 6 to 4 read zero
// - Bit 3 selects erase-verify mode
// - Bit 2 selects program-verify mode
// - Bit 1 selects erase mode
// - Bit 0 selects program mode
// - Boot receiver adapts bit rate up to 9600
// - Block select bits mark blocks eligible
// - Overlay bits 7 and 6 differing block program and erase
`ifndef FMC_DEFINES_SVH
`define FMC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FMC_MODE_CTRL_IDX 16'hFF80
`define FMC_LARGE_SEL_IDX 16'hFF82
`define FMC_SMALL_SEL_IDX 16'hFF83
`define FMC_WAIT_CTRL_IDX 16'hFFC2
`define FMC_RANGE_LO_IDX 16'hFF80
`define FMC_RANGE_HI_IDX 16'hFF83

// ----------------------------------------------------------------
// Reset and readback values
// ----------------------------------------------------------------
`define FMC_MODE_CTRL_RST 8'h00
`define FMC_LARGE_SEL_RST 8'hF0
`define FMC_SMALL_SEL_RST 8'h00
`define FMC_WAIT_CTRL_RST 8'h08
`define FMC_BLOCKED_READ 8'hFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FMC_SUPPLY_BIT 7
`define FMC_EVERIFY_BIT 3
`define FMC_PVERIFY_BIT 2
`define FMC_ERASE_BIT 1
`define FMC_PROG_BIT 0
`define FMC_OVL_SELECT_BIT 7
`define FMC_OVL_ZERO_BIT 6

// ----------------------------------------------------------------
// Array window and timing
// ----------------------------------------------------------------
`define FMC_ARRAY_TOP 16'h7FFF
`define FMC_CLK_HZ 20000000
`define FMC_MAX_BPS 9600
`define FMC_MIN_BIT_CYC (`FMC_CLK_HZ / `FMC_MAX_BPS)

`endif

// ===== src/fmc_pkg.sv
// Types shared by the flash mode control block
package fmc_pkg;

    typedef enum logic [1:0] {
        FMC_MODE_ILLEGAL,
        FMC_MODE_EXTERNAL,
        FMC_MODE_FLASH_MIN,
        FMC_MODE_FLASH_MAX
    } fmc_mode_e;

    typedef enum logic [1:0] {
        FMC_BAUD_IDLE,
        FMC_BAUD_MEASURE,
        FMC_BAUD_LOCKED
    } fmc_baud_e;

endpackage : fmc_pkg

// ===== src/fmc_top.sv
// Flash mode control: register file, array read port, boot autobaud
`timescale 1ns/1ns
`include "fmc_defines.svh"

module fmc_top #(
    parameter int BAUD_CNT_W = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Mode pins, supply detect and standby
    input wire logic mode_pin_high_i,
    input wire logic mode_pin_low_i,
    input wire logic programming_power_pin_i,
    input wire logic standby_i,
    // CPU read port to the array
    input wire logic mem_req_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic mem_word_i,
    output logic [15:0] mem_rdata_o,
    output logic mem_ack_o,
    output logic mem_ext_o,
    // Array side
    output logic [14:0] arr_addr_o,
    input wire logic [15:0] arr_rdata_i,
    // Operation controls toward the array
    output logic prog_en_o,
    output logic erase_en_o,
    output logic pverify_en_o,
    output logic everify_en_o,
    output logic [3:0] large_blk_o,
    output logic [7:0] small_blk_o,
    output logic reg_ext_o,
    output logic mode_illegal_o,
    // Boot serial channel
    input wire logic boot_mode_i,
    input wire logic boot_serial_in_i,
    output logic boot_serial_out_o,
    output logic [BAUD_CNT_W-1:0] baud_period_o,
    output logic baud_lock_o
);

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    fmc_pkg::fmc_mode_e mode;
    logic flash_en;
    logic supply;
    logic regs_ok;

    always_comb begin
        case ({mode_pin_high_i, mode_pin_low_i})
            2'b00: mode = fmc_pkg::FMC_MODE_ILLEGAL;
            2'b01: mode = fmc_pkg::FMC_MODE_EXTERNAL;
            2'b10: mode = fmc_pkg::FMC_MODE_FLASH_MIN;
            default: mode = fmc_pkg::FMC_MODE_FLASH_MAX;
        endcase
    end

    // Illegal setting treated as flash disabled, the safe side
    assign flash_en = (mode == fmc_pkg::FMC_MODE_FLASH_MIN) ||
                      (mode == fmc_pkg::FMC_MODE_FLASH_MAX);
    assign supply = programming_power_pin_i;
    assign regs_ok = flash_en && supply;

    // ----------------------------------------------------------------
    // AHB-Lite address phase
    // ----------------------------------------------------------------
    logic take;
    logic [15:0] a_idx;
    logic a_word_ok;
    logic in_range;

    assign take = hsel_i && htrans_i[1] && hready_i;
    assign a_idx = haddr_i[17:2];
    assign a_word_ok = (haddr_i[31:18] == 14'h0000);
    assign in_range = a_word_ok && (a_idx >= `FMC_RANGE_LO_IDX) &&
                      (a_idx <= `FMC_RANGE_HI_IDX);

    logic wr_pend_ff;
    logic rd_pend_ff;
    logic [15:0] idx_ff;
    logic hit_ff;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            idx_ff <= 16'h0000;
            hit_ff <= 1'b0;
        end else begin
            wr_pend_ff <= take && hwrite_i;
            rd_pend_ff <= take && !hwrite_i;
            if (take) begin
                idx_ff <= a_idx;
                hit_ff <= a_word_ok;
            end
        end
    end

    // Reads take one wait state so a write just before is seen
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= !(take && !hwrite_i);
            hresp_o <= 1'b0;
        end
    end

    // Mode 2 without supply sends the register window outside
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            reg_ext_o <= 1'b0;
        end else begin
            reg_ext_o <= take && in_range &&
                (mode == fmc_pkg::FMC_MODE_FLASH_MIN) && !supply;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [3:0] sel_ff;
    logic [3:0] large_ff;
    logic [7:0] small_ff;
    logic [7:0] wait_ctrl_ff;
    logic wr_ok;
    logic flash_clr;

    assign wr_ok = wr_pend_ff && hit_ff && regs_ok;
    assign flash_clr = !supply || standby_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            sel_ff <= 4'(`FMC_MODE_CTRL_RST);
        end else if (flash_clr) begin
            sel_ff <= 4'h0;
        end else if (wr_ok && idx_ff == `FMC_MODE_CTRL_IDX) begin
            sel_ff[`FMC_EVERIFY_BIT] <= hwdata_i[`FMC_EVERIFY_BIT];
            sel_ff[`FMC_PVERIFY_BIT] <= hwdata_i[`FMC_PVERIFY_BIT];
            sel_ff[`FMC_ERASE_BIT] <= hwdata_i[`FMC_ERASE_BIT];
            sel_ff[`FMC_PROG_BIT] <= hwdata_i[`FMC_PROG_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || flash_clr) begin
            // Upper half reads as ones and is not stored
            large_ff <= 4'(`FMC_LARGE_SEL_RST);
            small_ff <= `FMC_SMALL_SEL_RST;
        end else if (wr_ok && idx_ff == `FMC_LARGE_SEL_IDX) begin
            large_ff <= hwdata_i[3:0];
        end else if (wr_ok && idx_ff == `FMC_SMALL_SEL_IDX) begin
            small_ff <= hwdata_i[7:0];
        end
    end

    // Wait-state register survives software standby
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            wait_ctrl_ff <= `FMC_WAIT_CTRL_RST;
        end else if (wr_pend_ff && hit_ff &&
                     idx_ff == `FMC_WAIT_CTRL_IDX) begin
            wait_ctrl_ff <= hwdata_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [7:0] rd_val;
    logic [7:0] ctrl_view;
    logic reg_idx;

    assign ctrl_view = {supply, 3'b000, sel_ff};
    assign reg_idx = (idx_ff >= `FMC_RANGE_LO_IDX) &&
                     (idx_ff <= `FMC_RANGE_HI_IDX);

    always_comb begin
        rd_val = 8'h00;
        if (!hit_ff) begin
            rd_val = 8'h00;
        end else if (idx_ff == `FMC_WAIT_CTRL_IDX) begin
            rd_val = wait_ctrl_ff;
        end else if (!reg_idx) begin
            rd_val = 8'h00;
        end else if (mode == fmc_pkg::FMC_MODE_FLASH_MIN && !supply) begin
            rd_val = 8'h00;
        end else if (!regs_ok) begin
            rd_val = `FMC_BLOCKED_READ;
        end else if (idx_ff == `FMC_MODE_CTRL_IDX) begin
            rd_val = ctrl_view;
        end else if (idx_ff == `FMC_LARGE_SEL_IDX) begin
            rd_val = {4'hF, large_ff};
        end else if (idx_ff == `FMC_SMALL_SEL_IDX) begin
            rd_val = small_ff;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_pend_ff) begin
            hrdata_o <= {24'h00_0000, rd_val};
        end
    end

    // ----------------------------------------------------------------
    // Operation controls
    // ----------------------------------------------------------------
    logic ovl_protect;
    logic one_sel;

    assign ovl_protect = wait_ctrl_ff[`FMC_OVL_SELECT_BIT] ^
                         wait_ctrl_ff[`FMC_OVL_ZERO_BIT];
    assign one_sel = (sel_ff != 4'h0) &&
                     ((sel_ff & (sel_ff - 4'h1)) == 4'h0);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            prog_en_o <= 1'b0;
            erase_en_o <= 1'b0;
            pverify_en_o <= 1'b0;
            everify_en_o <= 1'b0;
        end else begin
            prog_en_o <= regs_ok && one_sel && !ovl_protect &&
                         sel_ff[`FMC_PROG_BIT];
            erase_en_o <= regs_ok && one_sel && !ovl_protect &&
                          sel_ff[`FMC_ERASE_BIT];
            pverify_en_o <= regs_ok && one_sel &&
                            sel_ff[`FMC_PVERIFY_BIT];
            everify_en_o <= regs_ok && one_sel &&
                            sel_ff[`FMC_EVERIFY_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            large_blk_o <= 4'h0;
            small_blk_o <= 8'h00;
            mode_illegal_o <= 1'b0;
        end else begin
            large_blk_o <= regs_ok ? large_ff : 4'h0;
            small_blk_o <= regs_ok ? small_ff : 8'h00;
            mode_illegal_o <= (mode == fmc_pkg::FMC_MODE_ILLEGAL);
        end
    end

    // ----------------------------------------------------------------
    // CPU read port
    // ----------------------------------------------------------------
    logic arr_hit;
    logic busy_ff;
    logic word_ff;
    logic odd_ff;

    assign arr_hit = flash_en && (mem_addr_i <= `FMC_ARRAY_TOP);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            busy_ff <= 1'b0;
            word_ff <= 1'b0;
            odd_ff <= 1'b0;
            arr_addr_o <= 15'h0000;
            mem_ext_o <= 1'b0;
        end else begin
            busy_ff <= mem_req_i && arr_hit && !busy_ff;
            mem_ext_o <= mem_req_i && !arr_hit;
            if (mem_req_i && arr_hit && !busy_ff) begin
                arr_addr_o <= {mem_addr_i[14:1], 1'b0};
                word_ff <= mem_word_i;
                odd_ff <= mem_addr_i[0];
            end
        end
    end

    // Second state returns the data; bytes land in the low lane
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 16'h0000;
        end else begin
            mem_ack_o <= busy_ff;
            if (busy_ff) begin
                if (word_ff) begin
                    mem_rdata_o <= arr_rdata_i;
                end else if (odd_ff) begin
                    mem_rdata_o <= {8'h00, arr_rdata_i[7:0]};
                end else begin
                    mem_rdata_o <= {8'h00, arr_rdata_i[15:8]};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Boot autobaud: width of the first low pulse is one bit
    // ----------------------------------------------------------------
    fmc_pkg::fmc_baud_e baud_st_ff;
    logic [BAUD_CNT_W-1:0] baud_cnt_ff;
    logic rx_prev_ff;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rx_prev_ff <= 1'b1;
        end else begin
            rx_prev_ff <= boot_serial_in_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i || !boot_mode_i) begin
            baud_st_ff <= fmc_pkg::FMC_BAUD_IDLE;
            baud_cnt_ff <= '0;
            baud_period_o <= '0;
            baud_lock_o <= 1'b0;
        end else begin
            case (baud_st_ff)
                fmc_pkg::FMC_BAUD_IDLE: begin
                    if (rx_prev_ff && !boot_serial_in_i) begin
                        baud_st_ff <= fmc_pkg::FMC_BAUD_MEASURE;
                        baud_cnt_ff <= BAUD_CNT_W'(1);
                    end
                end
                fmc_pkg::FMC_BAUD_MEASURE: begin
                    if (boot_serial_in_i) begin
                        baud_period_o <= baud_cnt_ff;
                        baud_lock_o <= 1'b1;
                        baud_st_ff <= fmc_pkg::FMC_BAUD_LOCKED;
                    end else if (baud_cnt_ff != '1) begin
                        baud_cnt_ff <= baud_cnt_ff + BAUD_CNT_W'(1);
                    end
                end
                default: begin
                    baud_st_ff <= fmc_pkg::FMC_BAUD_LOCKED;
                end
            endcase
        end
    end

    // Line held idle; the loader firmware drives replies
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            boot_serial_out_o <= 1'b1;
        end else begin
            boot_serial_out_o <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_prog_onehot: assert property (
        prog_en_o |-> $past(one_sel) && !erase_en_o && !pverify_en_o)
        else $error("program enabled with other select bits");
    a_ovl_blocks: assert property (
        $past(ovl_protect) |-> !prog_en_o && !erase_en_o)
        else $error("program or erase under overlay");
    a_prog_write: assert property (
        take && hwrite_i && haddr_i == 32'h0003_FE00 && regs_ok &&
        !standby_i ##1 hwdata_i[3:0] == 4'h1 && wait_ctrl_ff[7:6] == 2'b00
        && regs_ok && !standby_i |-> ##2 prog_en_o)
        else $error("program bit did not take");
    a_blocked_read: assert property (
        take && !hwrite_i && in_range && !regs_ok &&
        !(mode == fmc_pkg::FMC_MODE_FLASH_MIN && !supply)
        ##1 !regs_ok |-> ##1 hrdata_o[7:0] == 8'hFF && hreadyout_o)
        else $error("blocked register did not read H'FF");
    a_ctrl_supply: assert property (
        take && !hwrite_i && haddr_i == 32'h0003_FE00 && regs_ok
        ##1 regs_ok |-> ##1 hrdata_o[7] && hrdata_o[6:4] == 3'b000)
        else $error("supply flag or reserved bits wrong");
    a_no_supply_clr: assert property (
        !supply |=> sel_ff == 4'h0 && large_ff == 4'h0 && small_ff == 8'h00)
        else $error("flash registers not cleared");
    a_read_wait: assert property (
        take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    a_mem_two: assert property (
        mem_req_i && arr_hit && !busy_ff |-> ##2 mem_ack_o)
        else $error("array read not done in two states");
    a_ext_route: assert property (
        take && in_range && mode == fmc_pkg::FMC_MODE_FLASH_MIN && !supply
        |=> reg_ext_o)
        else $error("register window not routed outside");
    a_mode1_off: assert property (
        mode == fmc_pkg::FMC_MODE_EXTERNAL [*2] |-> !prog_en_o &&
        !erase_en_o && large_blk_o == 4'h0)
        else $error("operation with flash disabled");
    a_baud_lock: assert property (
        baud_st_ff == fmc_pkg::FMC_BAUD_MEASURE && boot_serial_in_i &&
        boot_mode_i |=> baud_lock_o && baud_period_o == $past(baud_cnt_ff))
        else $error("baud period not latched");

    c_prog: cover property (prog_en_o);
    c_erase: cover property (erase_en_o);
    c_everify: cover property (everify_en_o);
    c_baud: cover property (baud_lock_o);

endmodule : fmc_top

// ===== dv/fmc_arr_model.sv
// Behavioural flash array behind the block's array port
`timescale 1ns/1ns

module fmc_arr_model (
    // Array address and data
    input wire logic [14:0] arr_addr_i,
    output logic [15:0] arr_rdata_o
);
    // Address-derived pattern, so a wrong address or lane shows
    assign arr_rdata_o = {arr_addr_i[7:0] ^ 8'hA5, arr_addr_i[14:7]};
endmodule : fmc_arr_model

// ===== dv/tb.sv
// Self-checking bench for the flash mode control block
`timescale 1ns/1ns
`include "fmc_defines.svh"

module tb;
    localparam logic [31:0] A_MC = {14'h0000, `FMC_MODE_CTRL_IDX, 2'h0};
    localparam logic [31:0] A_LB = {14'h0000, `FMC_LARGE_SEL_IDX, 2'h0};
    localparam logic [31:0] A_SB = {14'h0000, `FMC_SMALL_SEL_IDX, 2'h0};
    localparam logic [31:0] A_WC = {14'h0000, `FMC_WAIT_CTRL_IDX, 2'h0};
    localparam int BIT_CYC = `FMC_MIN_BIT_CYC;
    logic sys_clk, rstn, hsel, hwrite, hready, hresp, rdy_s;
    int ext_cnt = 0;
    logic mode_hi, mode_lo, vpp, stby, boot, ser_in, sout, lock;
    logic mreq, mword, mack, mext, pe, ee, pve, eve, rext, mill;
    logic [31:0] haddr, hwdata, hrdata, rd_s;
    logic [1:0] htrans;
    logic [15:0] maddr, mrd_o, arr_rd, bper;
    logic [14:0] arr_a;
    logic [3:0] lblk;
    logic [7:0] sblk;
    logic ack, ext;
    logic [15:0] d16;
    int n_fail, cmp_count;

    fmc_top #(.BAUD_CNT_W(16)) dut_u (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .mode_pin_high_i(mode_hi), .mode_pin_low_i(mode_lo),
        .programming_power_pin_i(vpp), .standby_i(stby),
        .mem_req_i(mreq), .mem_addr_i(maddr), .mem_word_i(mword),
        .mem_rdata_o(mrd_o), .mem_ack_o(mack), .mem_ext_o(mext),
        .arr_addr_o(arr_a), .arr_rdata_i(arr_rd), .prog_en_o(pe),
        .erase_en_o(ee), .pverify_en_o(pve), .everify_en_o(eve),
        .large_blk_o(lblk), .small_blk_o(sblk), .reg_ext_o(rext),
        .mode_illegal_o(mill), .boot_mode_i(boot),
        .boot_serial_in_i(ser_in), .boot_serial_out_o(sout),
        .baud_period_o(bper), .baud_lock_o(lock)
    );
    fmc_arr_model arr_u (.arr_addr_i(arr_a), .arr_rdata_o(arr_rd));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Registered outputs, sampled mid-cycle to dodge edge races
    always @(negedge sys_clk) begin
        rdy_s <= hready;
        rd_s <= hrdata;
    end
    always @(posedge sys_clk) begin
        if (rext === 1'b1) begin
            ext_cnt <= ext_cnt + 1;
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e,
                       input string m);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t %s: got %h want %h", $time, m, s, e);
        end
    endtask : chk

    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (rdy_s !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (rdy_s !== 1'b1);
        rd = rd_s;
    endtask : ahb

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] d;
        ahb(1'b1, a, v, d);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] e,
                       input string m);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk(d, e, m);
        chk({31'h0, hresp}, 32'h0, "okay response");
    endtask : rdc

    task automatic mrd(input logic [15:0] a, input logic w);
        ack = 1'b0;
        ext = 1'b0;
        d16 = 16'h0;
        mreq <= 1'b1;
        maddr <= a;
        mword <= w;
        @(posedge sys_clk);
        mreq <= 1'b0;
        repeat (4) begin
            @(negedge sys_clk);
            if (mack === 1'b1) begin
                ack = 1'b1;
                d16 = mrd_o;
            end
            if (mext === 1'b1) begin
                ext = 1'b1;
            end
        end
        @(posedge sys_clk);
    endtask : mrd

    function automatic logic [15:0] arr_word(input logic [15:0] a);
        logic [14:0] w;
        w = {a[14:1], 1'b0};
        return {w[7:0] ^ 8'hA5, w[14:7]};
    endfunction : arr_word

    task automatic pins(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : pins

    task automatic t_regs;
        rdc(A_MC, 32'h80, "mode ctrl reset");
        rdc(A_LB, 32'hF0, "large reset");
        rdc(A_SB, 32'h00, "small reset");
        rdc(A_WC, 32'h08, "wait ctrl reset");
        rdc(A_MC + 32'h4, 32'h0, "unmapped");
        // One select bit at a time, as software must
        for (int i = 0; i < 4; i++) begin
            wr(A_MC, 32'h70 | (32'h1 << i));
            rdc(A_MC, 32'h80 | (32'h1 << i), "mode bit");
            @(negedge sys_clk);
            chk({eve, pve, ee, pe}, 32'h1 << i,
                "enable");
            @(posedge sys_clk);
        end
        wr(A_MC, 32'h0F);
        rdc(A_MC, 32'h8F, "all bits");
        @(negedge sys_clk);
        chk({28'h0, eve, pve, ee, pe}, 32'h0, "several bits");
        @(posedge sys_clk);
        wr(A_MC, 32'h0);
        wr(A_LB, 32'h05);
        wr(A_SB, 32'hA5);
        rdc(A_LB, 32'hF5, "large rw");
        rdc(A_SB, 32'hA5, "small rw");
        @(negedge sys_clk);
        chk({28'h0, lblk}, 32'h5, "large out");
        chk({24'h0, sblk}, 32'hA5, "small out");
        chk({28'h0, eve, pve, ee, pe}, 32'h0, "bits left");
        @(posedge sys_clk);
        $display("test regs done");
    endtask : t_regs

    task automatic t_overlay;
        wr(A_WC, 32'h80);
        wr(A_MC, 32'h01);
        pins(2);
        chk({31'h0, pe}, 32'h0, "overlay blocks program");
        wr(A_MC, 32'h04);
        pins(2);
        chk({31'h0, pve}, 32'h1, "overlay allows verify");
        wr(A_WC, 32'hC0);
        wr(A_MC, 32'h02);
        pins(2);
        chk({31'h0, ee}, 32'h1, "both overlay bits");
        wr(A_MC, 32'h00);
        wr(A_WC, 32'h08);
        $display("test overlay done");
    endtask : t_overlay

    task automatic t_clear;
        int e0;
        wr(A_MC, 32'h02);
        stby <= 1'b1;
        pins(2);
        stby <= 1'b0;
        pins(2);
        rdc(A_MC, 32'h80, "standby clear");
        rdc(A_LB, 32'hF0, "standby large");
        wr(A_LB, 32'h05);
        vpp <= 1'b0;
        pins(2);
        wr(A_LB, 32'h0A);
        rdc(A_MC, 32'hFF, "no supply mc");
        rdc(A_LB, 32'hFF, "no supply lb");
        rdc(A_SB, 32'hFF, "no supply sb");
        chk({28'h0, lblk}, 32'h0, "no supply blocks");
        vpp <= 1'b1;
        pins(2);
        rdc(A_MC, 32'h80, "supply back");
        rdc(A_LB, 32'hF0, "write ignored");
        mode_lo <= 1'b0;
        vpp <= 1'b0;
        pins(2);
        e0 = ext_cnt;
        rdc(A_MC, 32'h00, "mode 2 no supply");
        chk(ext_cnt - e0, 32'h1, "routed external");
        vpp <= 1'b1;
        pins(2);
        e0 = ext_cnt;
        wr(A_SB, 32'h03);
        rdc(A_SB, 32'h03, "mode 2 supply");
        chk(ext_cnt - e0, 32'h0, "kept internal");
        mode_lo <= 1'b1;
        pins(2);
        $display("test clear done");
    endtask : t_clear

    task automatic t_array;
        mrd(16'h1234, 1'b1);
        chk({ack, d16}, {1'b1, arr_word(16'h1234)}, "word");
        mrd(16'h1235, 1'b0);
        chk({ack, d16[7:0]}, {1'b1, 8'(arr_word(16'h1235))}, "odd");
        mrd(16'h7FFE, 1'b0);
        chk({ack, d16[7:0]}, {1'b1, 8'(arr_word(16'h7FFE) >> 8)},
            "even");
        mrd(16'h8000, 1'b1);
        chk({30'h0, ack, ext}, 32'h1, "above array");
        mode_hi <= 1'b0;
        pins(2);
        mrd(16'h0100, 1'b1);
        chk({30'h0, ack, ext}, 32'h1, "mode 1 external");
        wr(A_SB, 32'h11);
        rdc(A_SB, 32'hFF, "mode 1 sb");
        rdc(A_MC, 32'hFF, "mode 1 mc");
        rdc(A_LB, 32'hFF, "mode 1 lb");
        mode_lo <= 1'b0;
        pins(2);
        chk({31'h0, mill}, 32'h1, "illegal mode");
        rdc(A_MC, 32'hFF, "mode 0 mc");
        mode_hi <= 1'b1;
        pins(2);
        mrd(16'h0002, 1'b1);
        chk({31'h0, ack}, 32'h1, "mode 2 flash");
        mode_lo <= 1'b1;
        pins(2);
        $display("test array done");
    endtask : t_array

    task automatic t_boot;
        boot <= 1'b1;
        pins(2);
        ser_in <= 1'b0;
        pins(BIT_CYC);
        ser_in <= 1'b1;
        pins(3);
        chk({16'h0, bper}, BIT_CYC, "bit period");
        chk({30'h0, lock, sout}, 32'h3, "lock and idle out");
        boot <= 1'b0;
        pins(3);
        chk({31'h0, lock}, 32'h0, "lock dropped");
        $display("test boot done");
    endtask : t_boot

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #(50 * 60000);
        n_fail++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        {rstn, hsel, hwrite, stby, boot, mreq, mword} = 7'h0;
        {haddr, hwdata, htrans, maddr} = 82'h0;
        {mode_hi, mode_lo, vpp, ser_in} = 4'hF;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_overlay();
        t_clear();
        t_array();
        t_boot();
        report_and_stop();
    end
endmodule : tb
